// ### rtl/ahb_reg_bridge.sv
// AHB-Lite slave that turns bus transfers into register strobes.
// Assumes single word transfers; zero wait states and OKAY answers.
`timescale 1ns/1ps
module ahb_reg_bridge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    reg_bus_if.bridge rb
);
    logic take;
    logic wr_q;
    logic [7:0] addr_q;

    assign take = hsel & hready & htrans[1];
    assign rb.wr = wr_q;
    assign rb.waddr = addr_q;
    assign rb.wdata = hwdata;
    assign rb.raddr = haddr[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_q <= take & hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take) begin
                addr_q <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata <= rb.rdata;
            end
        end
    end
endmodule

// ### rtl/link_out_stage.sv
// Output registers of the links: shared word and control, one strobe each.
// Assumes the core loads only when the stage reports no word pending.
`timescale 1ns/1ps
module link_out_stage (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [3:0] sel,
    input wire logic [31:0] word,
    input wire logic ctrl,
    input wire logic axis_mode,
    input wire logic [15:0] ready,
    output logic [31:0] word_q,
    output logic ctrl_q,
    output logic [15:0] valid_q,
    output logic pending
);
    assign pending = |valid_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_q <= 32'h0000_0000;
            ctrl_q <= 1'b0;
        end else if (load) begin
            word_q <= word;
            ctrl_q <= ctrl;
        end
    end

    // Full-flag links see a one-cycle strobe; stream links hold valid.
    for (genvar i = 0; i < 16; i++) begin : g_link
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                valid_q[i] <= 1'b0;
            end else if (load && sel == 4'(i)) begin
                valid_q[i] <= 1'b1;
            end else begin
                valid_q[i] <= valid_q[i] & axis_mode & ~ready[i];
            end
        end
    end
endmodule

// ### rtl/reg_bus_if.sv
// Internal register access path between the bus bridge and the core.
// Assumes both ends share one clock; writes are one-cycle strobes.
`timescale 1ns/1ps
interface reg_bus_if;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [7:0] raddr;
    logic [31:0] rdata;
    modport bridge(output wr, waddr, wdata, raddr, input rdata);
    modport regs(input wr, waddr, wdata, raddr, output rdata);
endinterface

// ### rtl/stream_link_pkg.sv
// Constants, field positions and types for the stream link write port.
// Assumes one clock domain and an AHB-Lite register bus of 32-bit words.
//
// How it works
// - Static write sends the source word to the link named by instruction bits 0-3.
// - Dynamic write takes the link number from the low four bits of source B.
// - Blocking writes stall until the selected link has room, then write.
// - Non-blocking writes never stall; carry is 0 with room, 1 when full.
// - Carry follows the full flag, or the handshake state in stream mode.
// - Control flag or last marker carries the instruction's control bit.
// - Test writes behave normally but never raise the link write strobe.
// - Atomic instructions hold off interrupts between them; exceptions still happen.
// - User mode with protection on raises privilege exception 00111, no write.
// - A write takes one cycle, or two with area saving on, plus stalls.
// - Static blocking stall takes interrupts only with extended ops and not atomic.
// - Dynamic blocking stall takes interrupts unless the instruction is atomic.
// - Static writes need links; their atomic forms also need extended ops.
// - Dynamic writes need links and the extended ops option.
package stream_link_pkg;
    localparam int LINKS = 16;
    localparam int DW = 32;
    localparam logic [5:0] OP_STATIC = 6'h1b;
    localparam logic [5:0] OP_DYNAMIC = 6'h13;
    localparam int OP_LO = 26;
    localparam int ST_SEL_BIT = 15;
    localparam int ST_N_BIT = 14;
    localparam int ST_C_BIT = 13;
    localparam int ST_T_BIT = 12;
    localparam int ST_A_BIT = 11;
    localparam int DY_SEL_BIT = 10;
    localparam int DY_N_BIT = 9;
    localparam int DY_C_BIT = 8;
    localparam int DY_T_BIT = 7;
    localparam int DY_A_BIT = 6;
    localparam logic [4:0] EC_PRIV = 5'h07;
    localparam logic [4:0] EC_ILLEGAL = 5'h01;
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0c;
    localparam int CFG_AREA = 0;
    localparam int CFG_EXT = 1;
    localparam int CFG_ALLOW = 2;
    localparam int CFG_AXIS = 3;
    localparam int CFG_MMU_LO = 4;
    localparam int CFG_CNT_LO = 8;
    localparam logic [31:0] CFG_RST = 32'h0000_1002;
    localparam int EV_DONE = 0;
    localparam int EV_FULL = 1;
    localparam int EV_PRIV = 2;
    localparam int EV_ILLEGAL = 3;
    localparam int EV_INTR = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] EV_RST = 5'h00;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PREP = 2'b01,
        ST_RUN = 2'b10
    } state_e;
endpackage

// ### rtl/stream_link_write_port.sv
// Stream write execution port with its register file and interrupt.
// Assumes the pipeline offers one instruction at a time and waits for
// issue_done, exc_valid or intr_take before offering the next.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module stream_link_write_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] issue_src_a,
    input wire logic [31:0] issue_src_b,
    input wire logic user_mode_flag,
    input wire logic intr_pending,
    output logic issue_stall,
    output logic issue_done,
    output logic status_carry_flag,
    output logic carry_write,
    output logic exc_valid,
    output logic [4:0] exception_cause_code,
    output logic intr_take,
    output logic intr_hold,
    output logic [31:0] link_out_word,
    output logic link_out_ctrl_flag,
    output logic [15:0] link_out_write,
    input wire logic [15:0] link_out_full_flag,
    input wire logic [15:0] link_out_ready
);
    reg_bus_if rb();
    stream_link_pkg::state_e state_q;
    stream_link_pkg::state_e state_d;
    logic [31:0] cfg_q;
    logic [4:0] status_q;
    logic [4:0] mask_q;
    logic [4:0] ev;
    logic area_saving_option;
    logic extended_stream_ops_option;
    logic user_stream_access_allow;
    logic axis_mode;
    logic [1:0] mmu_config_level;
    logic [4:0] stream_link_count;
    logic is_static;
    logic is_dyn;
    logic op_n;
    logic op_c;
    logic op_t;
    logic op_a;
    logic [3:0] link_select_field;
    logic legal;
    logic priv;
    logic take;
    logic n_q;
    logic c_q;
    logic t_q;
    logic a_q;
    logic dyn_q;
    logic [3:0] sel_q;
    logic [31:0] word_q;
    logic pending;
    logic space;
    logic run;
    logic finish;
    logic may_intr;
    logic load;

    ////////////////////////////////////////////////////////////////////////
    ahb_reg_bridge u_bridge (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rb(rb.bridge)
    );

    assign area_saving_option = cfg_q[stream_link_pkg::CFG_AREA];
    assign extended_stream_ops_option = cfg_q[stream_link_pkg::CFG_EXT];
    assign user_stream_access_allow = cfg_q[stream_link_pkg::CFG_ALLOW];
    assign axis_mode = cfg_q[stream_link_pkg::CFG_AXIS];
    assign mmu_config_level = cfg_q[stream_link_pkg::CFG_MMU_LO +: 2];
    assign stream_link_count = cfg_q[stream_link_pkg::CFG_CNT_LO +: 5];

    always_comb begin
        unique case (rb.raddr)
            stream_link_pkg::OFF_CFG: rb.rdata = cfg_q;
            stream_link_pkg::OFF_STATUS: rb.rdata = {27'h0, status_q};
            stream_link_pkg::OFF_MASK: rb.rdata = {27'h0, mask_q};
            stream_link_pkg::OFF_STATE: rb.rdata = {20'h0, sel_q,
                exception_cause_code, pending, issue_stall,
                status_carry_flag};
            default: rb.rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= stream_link_pkg::CFG_RST;
        end else if (rb.wr && rb.waddr == stream_link_pkg::OFF_CFG) begin
            cfg_q <= rb.wdata & 32'h0000_1f3f;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= stream_link_pkg::EV_RST;
        end else if (rb.wr && rb.waddr == stream_link_pkg::OFF_MASK) begin
            mask_q <= rb.wdata[4:0];
        end
    end

    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= stream_link_pkg::EV_RST;
            irq <= 1'b0;
        end else begin
            if (rb.wr && rb.waddr == stream_link_pkg::OFF_STATUS) begin
                status_q <= (status_q & ~rb.wdata[4:0]) | ev;
            end else begin
                status_q <= status_q | ev;
            end
            irq <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign is_static = issue_instr[31:stream_link_pkg::OP_LO] ==
        stream_link_pkg::OP_STATIC && issue_instr[stream_link_pkg::ST_SEL_BIT];
    assign is_dyn = issue_instr[31:stream_link_pkg::OP_LO] ==
        stream_link_pkg::OP_DYNAMIC && issue_instr[stream_link_pkg::DY_SEL_BIT];
    assign op_n = is_static ? issue_instr[stream_link_pkg::ST_N_BIT]
                            : issue_instr[stream_link_pkg::DY_N_BIT];
    assign op_c = is_static ? issue_instr[stream_link_pkg::ST_C_BIT]
                            : issue_instr[stream_link_pkg::DY_C_BIT];
    assign op_t = is_static ? issue_instr[stream_link_pkg::ST_T_BIT]
                            : issue_instr[stream_link_pkg::DY_T_BIT];
    assign op_a = is_static ? issue_instr[stream_link_pkg::ST_A_BIT]
                            : issue_instr[stream_link_pkg::DY_A_BIT];
    assign link_select_field = is_static ? issue_instr[3:0]
                                         : issue_src_b[3:0];
    assign legal = is_static ? (stream_link_count != 5'h00 &&
                                (!op_a || extended_stream_ops_option))
                             : (stream_link_count != 5'h00 &&
                                extended_stream_ops_option);
    assign priv = mmu_config_level != 2'h0 && !user_stream_access_allow &&
                  user_mode_flag;
    assign take = state_q == stream_link_pkg::ST_IDLE && issue_valid &&
                  (is_static || is_dyn);

    // Stream mode counts a link as having room once no word is pending.
    assign space = axis_mode ? !pending : !link_out_full_flag[sel_q];
    assign run = state_q == stream_link_pkg::ST_RUN;
    assign finish = run && (space || n_q);
    assign may_intr = run && !space && !n_q && intr_pending && !a_q &&
                      (dyn_q || extended_stream_ops_option);
    assign load = run && space && !t_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            stream_link_pkg::ST_IDLE: begin
                if (take && legal && !priv) begin
                    state_d = area_saving_option ? stream_link_pkg::ST_PREP
                                                 : stream_link_pkg::ST_RUN;
                end
            end
            stream_link_pkg::ST_PREP: state_d = stream_link_pkg::ST_RUN;
            stream_link_pkg::ST_RUN: begin
                if (finish || may_intr) begin
                    state_d = stream_link_pkg::ST_IDLE;
                end
            end
            default: state_d = stream_link_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= stream_link_pkg::ST_IDLE;
            issue_stall <= 1'b0;
        end else begin
            state_q <= state_d;
            issue_stall <= state_d != stream_link_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_q <= 1'b0;
            c_q <= 1'b0;
            t_q <= 1'b0;
            a_q <= 1'b0;
            dyn_q <= 1'b0;
            sel_q <= 4'h0;
            word_q <= 32'h0000_0000;
        end else if (take) begin
            n_q <= op_n;
            c_q <= op_c;
            t_q <= op_t;
            a_q <= op_a;
            dyn_q <= is_dyn;
            sel_q <= link_select_field;
            word_q <= issue_src_a;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            issue_done <= 1'b0;
            carry_write <= 1'b0;
            status_carry_flag <= 1'b0;
            intr_take <= 1'b0;
        end else begin
            issue_done <= finish;
            carry_write <= finish && n_q;
            intr_take <= may_intr;
            if (finish && n_q) begin
                status_carry_flag <= !space;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_valid <= 1'b0;
            exception_cause_code <= 5'h00;
        end else begin
            exc_valid <= take && (priv || !legal);
            if (take && priv) begin
                exception_cause_code <= stream_link_pkg::EC_PRIV;
            end else if (take && !legal) begin
                exception_cause_code <= stream_link_pkg::EC_ILLEGAL;
            end
        end
    end

    // Interrupts stay blocked across an atomic group; exceptions end it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intr_hold <= 1'b0;
        end else if (take) begin
            intr_hold <= op_a && legal && !priv;
        end else if (finish) begin
            intr_hold <= a_q;
        end
    end

    always_comb begin
        ev = 5'h00;
        ev[stream_link_pkg::EV_DONE] = finish;
        ev[stream_link_pkg::EV_FULL] = finish && n_q && !space;
        ev[stream_link_pkg::EV_PRIV] = take && priv;
        ev[stream_link_pkg::EV_ILLEGAL] = take && !priv && !legal;
        ev[stream_link_pkg::EV_INTR] = may_intr;
    end

    ////////////////////////////////////////////////////////////////////////
    link_out_stage u_stage (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(load),
        .sel(sel_q),
        .word(word_q),
        .ctrl(c_q),
        .axis_mode(axis_mode),
        .ready(link_out_ready),
        .word_q(link_out_word),
        .ctrl_q(link_out_ctrl_flag),
        .valid_q(link_out_write),
        .pending(pending)
    );

    ////////////////////////////////////////////////////////////////////////
    static_link_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && is_static |-> link_select_field == issue_instr[3:0])
        else $error("static link index not from instruction");
    dynamic_link_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && is_dyn |=> sel_q == $past(issue_src_b[3:0]))
        else $error("dynamic link index not from source b");
    blocking_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && !n_q && !space && !may_intr |=> run && issue_stall)
        else $error("blocking write left before room");
    nonblock_carry_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && n_q |=> issue_done && carry_write &&
        status_carry_flag == !$past(space))
        else $error("non-blocking carry wrong or stalled");
    carry_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && n_q && !axis_mode |=>
        status_carry_flag == $past(link_out_full_flag[sel_q]))
        else $error("carry not equal to full flag");
    ctrl_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        load |=> link_out_ctrl_flag == $past(c_q))
        else $error("control flag differs from instruction");
    test_nowrite_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && t_q && !pending |=> link_out_write == 16'h0000)
        else $error("test write raised a strobe");
    atomic_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && a_q |-> !may_intr ##1 !intr_take)
        else $error("atomic write was interrupted");
    priv_exc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && priv |=> exc_valid && exception_cause_code == 5'h07 &&
        state_q == stream_link_pkg::ST_IDLE && !issue_done)
        else $error("privilege exception missing");
    latency_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && legal && !priv && area_saving_option |=>
        state_q == stream_link_pkg::ST_PREP ##1 run)
        else $error("area saving latency not two cycles");
    static_intr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && !dyn_q && !extended_stream_ops_option |-> !may_intr)
        else $error("static stall took interrupt without option");
    dynamic_intr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run && dyn_q && !a_q && !n_q && !space && intr_pending
        |=> intr_take && !issue_stall)
        else $error("dynamic stall ignored interrupt");
    static_avail_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && is_static && op_a && !extended_stream_ops_option && !priv
        |=> exc_valid && state_q == stream_link_pkg::ST_IDLE)
        else $error("static atomic accepted without option");
    dynamic_avail_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && is_dyn && (!extended_stream_ops_option ||
        stream_link_count == 5'h00) |-> !legal)
        else $error("dynamic write accepted when unavailable");
    stream_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        axis_mode && (link_out_write & ~link_out_ready) != 16'h0 |=>
        $stable(link_out_write) && $stable(link_out_word) &&
        $stable(link_out_ctrl_flag))
        else $error("stream valid or data dropped before ready");
endmodule

// ### sim/link_receiver_model.sv
// Behavioural receiver on the far side of all sixteen links.
// Assumes the bench says which links stay full and for how long.
`timescale 1ns/1ps
module link_receiver_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] link_out_write,
    input wire logic [15:0] busy_mask,
    input wire logic [7:0] busy_len,
    input wire logic busy_go,
    output logic [15:0] link_out_full_flag,
    output logic [15:0] link_out_ready,
    output logic [7:0] got_cnt_q
);
    logic [7:0] left_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_q <= 8'h00;
        end else if (busy_go) begin
            left_q <= busy_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign link_out_full_flag = (left_q != 8'h00) ? busy_mask : 16'h0000;
    // A stream word is taken only where the link has room.
    assign link_out_ready = ~link_out_full_flag;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            got_cnt_q <= 8'h00;
        end else if ((link_out_write & link_out_ready) != 16'h0000) begin
            got_cnt_q <= got_cnt_q + 8'h01;
        end
    end
endmodule

// ### sim/stream_link_write_port_test.sv
// Bench for the stream write port: bus and issue tasks, then scenarios.
// Assumes one 250 MHz clock and the receiver model on every link.
`timescale 1ns/1ps
module stream_link_write_port_test;
    localparam logic [31:0] ILL = {26'h0, 1'b1, stream_link_pkg::EC_ILLEGAL};
    localparam logic [31:0] PRV = {26'h0, 1'b1, stream_link_pkg::EC_PRIV};
    localparam logic [7:0] CFG = stream_link_pkg::OFF_CFG,
        STS = stream_link_pkg::OFF_STATUS, MSK = stream_link_pkg::OFF_MASK;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0, issue_src_a = 32'h0, issue_src_b = 32'h0;
    logic user_mode_flag = 1'b0, intr_pending = 1'b0, busy_go = 1'b0;
    logic [15:0] busy_mask = 16'h0, link_out_write, wr;
    logic [15:0] link_out_full_flag, link_out_ready;
    logic [7:0] busy_len = 8'h0, got_cnt_q;
    logic hready, hreadyout, hresp, irq, issue_stall, issue_done, cf, cy;
    logic status_carry_flag, carry_write, exc_valid, intr_take, intr_hold;
    logic link_out_ctrl_flag, ex, it;
    logic [31:0] hrdata, link_out_word, wd, r, lat;
    logic [4:0] exception_cause_code, ec;
    int n_errors = 0, comparisons = 0, cycles = 0;
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    stream_link_write_port i_stream_link_write_port (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .issue_valid,
        .issue_instr, .issue_src_a, .issue_src_b, .user_mode_flag,
        .intr_pending, .issue_stall, .issue_done, .status_carry_flag,
        .carry_write, .exc_valid, .exception_cause_code, .intr_take,
        .intr_hold, .link_out_word, .link_out_ctrl_flag, .link_out_write,
        .link_out_full_flag, .link_out_ready);
    link_receiver_model i_link_receiver_model (
        .hclk, .hresetn, .link_out_write, .busy_mask, .busy_len, .busy_go,
        .link_out_full_flag, .link_out_ready, .got_cnt_q);
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic busy(input logic [15:0] m, input logic [7:0] l);
        @(posedge hclk);
        busy_mask <= m;
        busy_len <= l;
        busy_go <= 1'b1;
        @(posedge hclk);
        busy_go <= 1'b0;
    endtask
    // Offers one instruction and samples the outcome mid-cycle.
    task automatic put(input logic [31:0] ins, a, b);
        @(posedge hclk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        issue_src_a <= a;
        issue_src_b <= b;
        @(posedge hclk);
        issue_valid <= 1'b0;
        lat = 0;
        do begin
            @(negedge hclk);
            lat = lat + 1;
        end while (!(issue_done === 1'b1 || exc_valid === 1'b1 ||
                     intr_take === 1'b1) && lat < 80);
        wr = link_out_write;
        wd = link_out_word;
        cf = link_out_ctrl_flag;
        cy = status_carry_flag;
        ex = exc_valid;
        ec = exception_cause_code;
        it = intr_take;
    endtask
    // Field f packs the non-blocking, control, test and atomic bits.
    function automatic logic [31:0] st(input logic [3:0] f, x);
        return {stream_link_pkg::OP_STATIC, 10'h0, 1'b1, f, 7'h0, x};
    endfunction
    function automatic logic [31:0] dy(input logic [3:0] f);
        return {stream_link_pkg::OP_DYNAMIC, 15'h0, 1'b1, f, 6'h0};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, CFG, 32'h0, r);
        chk("cfg", stream_link_pkg::CFG_RST, r);
        bus(1'b0, MSK, 32'h0, r);
        chk("mask", 32'h0, r);
        put(st(4'h0, 4'h3), 32'hcafe_0003, 32'h0);
        chk("write", 32'h0008, 32'(wr));
        chk("word", 32'hcafe_0003, wd);
        chk("ctrl", 32'h0, 32'(cf));
        chk("latency", 32'd2, lat);
        put(dy(4'h4), 32'h1234_5678, 32'hffff_fff5);
        chk("write", 32'h0020, 32'(wr));
        chk("ctrl", 32'h1, 32'(cf));
        put(st(4'h2, 4'h6), 32'h0, 32'h0);
        chk("test", 32'h0, 32'(wr));
        busy(16'h0004, 8'd40);
        put(st(4'h8, 4'h2), 32'h0, 32'h0);
        chk("carry", 32'h1, 32'(cy));
        chk("write", 32'h0, 32'(wr));
        chk("latency", 32'd2, lat);
        put(st(4'h8, 4'h7), 32'h77, 32'h0);
        chk("carry", 32'h0, 32'(cy));
        chk("write", 32'h0080, 32'(wr));
        busy(16'h0100, 8'd10);
        put(st(4'h0, 4'h8), 32'h88, 32'h0);
        chk("stall", 32'h1, 32'(lat > 5));
        chk("write", 32'h0100, 32'(wr));
        intr_pending <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            busy(16'h0200, 8'd30);
            put(k ? dy(4'h0) : st(4'h0, 4'h9), 32'h0, 32'h9);
            chk("intr_take", 32'h1, 32'(it));
            busy(16'h0200, 8'd12);
            put(k ? dy(4'h1) : st(4'h1, 4'h9), 32'h0, 32'h9);
            chk("atomic", 32'h0200, 32'(wr));
            chk("intr_hold", 32'h1, 32'(intr_hold));
        end
        intr_pending <= 1'b0;
        bus(1'b1, CFG, 32'h0000_1012, r);
        user_mode_flag <= 1'b1;
        put(st(4'h0, 4'h1), 32'h1, 32'h0);
        chk("privilege", PRV, {26'h0, ex, ec});
        chk("write", 32'h0, 32'(wr));
        bus(1'b1, CFG, 32'h0000_1016, r);
        put(st(4'h0, 4'h1), 32'h1, 32'h0);
        chk("allowed", 32'h0002, 32'(wr));
        user_mode_flag <= 1'b0;
        bus(1'b1, CFG, 32'h0000_1000, r);
        put(dy(4'h0), 32'h0, 32'h3);
        chk("no dynamic", ILL, {26'h0, ex, ec});
        put(st(4'h1, 4'h3), 32'h0, 32'h0);
        chk("no atomic", ILL, {26'h0, ex, ec});
        put(st(4'h0, 4'h3), 32'h0, 32'h0);
        chk("static", 32'h0008, 32'(wr));
        bus(1'b1, CFG, 32'h0000_0002, r);
        put(st(4'h0, 4'h3), 32'h0, 32'h0);
        chk("no links", ILL, {26'h0, ex, ec});
        bus(1'b1, CFG, 32'h0000_100b, r);
        put(st(4'h0, 4'h1), 32'h1, 32'h0);
        chk("latency", 32'd3, lat);
        busy(16'h0010, 8'd12);
        put(st(4'h0, 4'h4), 32'h44, 32'h0);
        put(st(4'h8, 4'h5), 32'h55, 32'h0);
        chk("axis", 32'h8010_0044, {cy, wr[14:0], wd[15:0]});
        bus(1'b0, STS, 32'h0, r);
        chk("status", 32'h1f, r);
        chk("irq masked", 32'h0, 32'(irq));
        bus(1'b1, MSK, 32'h1f, r);
        repeat (2) @(negedge hclk);
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, STS, 32'h1f, r);
        repeat (2) @(negedge hclk);
        chk("irq cleared", 32'h0, 32'(irq));
        bus(1'b0, 8'h10, 32'h0, r);
        chk("unmapped", 32'h0, r);
        chk("got", 32'h0a, 32'(got_cnt_q));
        print_verdict();
    end
endmodule
